// File: adc_seq_checker.sv
`timescale 1ns/1ns
`include "adc_seq_params.svh"
module adc_seq_checker (
    // Watched ports
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [`DATA_W-1:0] o_rdata,
    input wire logic i_ctl_write,
    input wire logic i_start_write,
    input wire logic i_operator_write,
    input wire logic i_scan_mode,
    input wire logic i_conv_done,
    input wire logic i_conv_last,
    input wire logic o_result_store,
    input wire logic o_conversion_done_set,
    input wire logic o_abort,
    input wire logic o_running
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    wire logic halt = i_ctl_write || i_operator_write || (i_wr && i_addr == `OFS_CMP_ENABLE);
    property p_store; o_result_store |-> $past(i_conv_done && o_running && !halt); endproperty
    a_store: assert property (p_store) else $error("store without conversion");
    property p_set; o_conversion_done_set |-> $past(i_conv_done && o_running); endproperty
    a_set: assert property (p_set) else $error("done set without conversion");
    property p_set_store; o_result_store |-> o_conversion_done_set; endproperty
    a_set_store: assert property (p_set_store) else $error("store without done set");
    property p_abort; o_running && halt |=> o_abort && !o_running; endproperty
    a_abort: assert property (p_abort) else $error("abort missed");
    property p_abort_src; o_abort |-> $past(o_running && halt) && !o_result_store; endproperty
    a_abort_src: assert property (p_abort_src) else $error("abort without cause");
    property p_start; i_start_write && !halt |=> o_running; endproperty
    a_start: assert property (p_start) else $error("start ignored");
    property p_end; o_running && i_conv_done && i_conv_last && !i_scan_mode && !i_start_write |=> !o_running; endproperty
    a_end: assert property (p_end) else $error("sequence did not end");
    property p_stat; $past(i_rd && i_addr == `OFS_STATUS) |-> o_rdata[15:8] == 8'h00 && !o_rdata[6]; endproperty
    a_stat: assert property (p_stat) else $error("status unused bits set");
endmodule
bind adc_sequence_status_compare adc_seq_checker u_adc_seq_checker (.i_clk, .i_reset, .i_addr, .i_wr, .i_rd,
    .o_rdata, .i_ctl_write, .i_start_write, .i_operator_write, .i_scan_mode, .i_conv_done, .i_conv_last,
    .o_result_store, .o_conversion_done_set, .o_abort, .o_running);

// File: adc_seq_params.svh
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// Register bus widths
`define ADDR_W 5
`define DATA_W 16

// Byte offsets
`define OFS_STATUS 5'h06
`define OFS_CMP_ENABLE 5'h08
`define OFS_IRQ_STATUS 5'h10
`define OFS_IRQ_MASK 5'h12
`define OFS_ENGINE 5'h14

// Sequence status field positions
`define BIT_SEQ_DONE 7
`define BIT_TRIG_OVR 5
`define BIT_RES_OVR 4
`define CNT_MSB 3
`define CNT_LSB 0

// Interrupt status / mask field positions
`define IRQ_SEQ_DONE 0
`define IRQ_TRIG_OVR 1
`define IRQ_RES_OVR 2
`define IRQ_W 3

// Widths and reset values
`define CNT_W 4
`define POS_N 16
`define RESULT_W 12
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CMP_RESET 16'h0000
`define IRQ_RESET 3'h0
`define RDATA_ZERO 16'h0000

`endif

// File: adc_seq_pkg.sv
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } seq_state_t;

    typedef logic [3:0] conv_index_t;

endpackage

// File: adc_sequence_status_compare.sv
`timescale 1ns/1ns
`include "adc_seq_params.svh"
// Functional notes
// - Set sequence-done at each sequence end
// - Clear done on W1, start write, fast read
// - Edge mode: extra trigger while running sets overrun
// - Clear trigger overrun on W1 or control writes
// - Result write while done flag set: overrun
// - Clear result overrun on W1 or control writes
// - Four-bit counter indexes current result register
// - Non-FIFO: counter zeroed at sequence start, end
// - FIFO: counter keeps running, wraps at max
// - Abort or new start clears counter always
// - Status register writes never change counter bits
// - Sixteen compare enable bits, one per position
// - Compare enable write aborts running sequence
// - Successful compare signalled by conversion-done flag
// - Direction clear: lower-or-equal; set: strictly higher
// - Compare enabled: result discarded, not stored
module adc_sequence_status_compare (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic [`DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`DATA_W-1:0] o_rdata,
    // Write and read strobes of neighbouring registers
    input wire logic i_ctl_write,
    input wire logic i_start_write,
    input wire logic i_operator_write,
    input wire logic i_result_read,
    // Mode bits held elsewhere
    input wire logic i_fifo_mode,
    input wire logic i_scan_mode,
    input wire logic i_trigger_level_select,
    input wire logic i_fast_flag_clear,
    // Conversion engine
    input wire logic i_trigger_edge,
    input wire logic i_conv_done,
    input wire logic i_conv_last,
    input wire logic [`RESULT_W-1:0] i_conv_result,
    input wire logic [`RESULT_W-1:0] i_compare_value,
    input wire logic [`POS_N-1:0] i_compare_higher_select,
    input wire logic [`POS_N-1:0] i_conversion_done_flag,
    // Result register and flag control
    output logic o_result_store,
    output adc_seq_pkg::conv_index_t o_result_index,
    output logic [`RESULT_W-1:0] o_result_data,
    output logic o_conversion_done_set,
    output logic o_abort,
    output logic o_running,
    // Interrupt
    output logic o_irq
);
    import adc_seq_pkg::*;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    seq_state_t state_reg;
    seq_state_t state_next;
    logic sequence_done_flag;
    logic trigger_overrun_flag;
    logic result_overrun_flag;
    conv_index_t conversion_counter;
    logic [`POS_N-1:0] compare_enable_reg;
    logic [`IRQ_W-1:0] irq_status_reg;
    logic [`IRQ_W-1:0] irq_mask_reg;

    logic wr_status;
    logic wr_cmp;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic abort_req;
    logic seq_start;
    logic seq_end;
    logic cmp_on;
    logic cmp_true;
    logic store_now;
    logic seq_done_set;
    logic trig_ovr_set;
    logic res_ovr_set;
    logic running;
    logic abort_running;
    logic conv_taken;
    logic cmp_hit_now;
    logic [`DATA_W-1:0] status_word;
    logic [`DATA_W-1:0] rdata_next;
    logic [`IRQ_W-1:0] irq_set;
    logic [`IRQ_W-1:0] irq_status_next;
    logic [`IRQ_W-1:0] irq_mask_next;

    // Address decode
    always_comb begin
        wr_status = 1'b0;
        wr_cmp = 1'b0;
        wr_irq_status = 1'b0;
        wr_irq_mask = 1'b0;
        if (i_wr && hit(i_addr, `OFS_STATUS)) begin
            wr_status = 1'b1;
        end else if (i_wr && hit(i_addr, `OFS_CMP_ENABLE)) begin
            wr_cmp = 1'b1;
        end else if (i_wr && hit(i_addr, `OFS_IRQ_STATUS)) begin
            wr_irq_status = 1'b1;
        end else if (i_wr && hit(i_addr, `OFS_IRQ_MASK)) begin
            wr_irq_mask = 1'b1;
        end
    end

    // Any control, compare enable or operator write aborts
    assign abort_req = i_ctl_write | wr_cmp | i_operator_write;
    // A start write begins a new sequence; the trigger starts one only when idle
    assign seq_start = i_start_write | (i_trigger_edge & (state_reg == ST_IDLE));
    assign seq_end = (state_reg == ST_RUN) & i_conv_done & i_conv_last & ~abort_req;

    // Compare on the position under the counter
    assign cmp_on = compare_enable_reg[conversion_counter];
    always_comb begin
        if (i_compare_higher_select[conversion_counter]) begin
            cmp_true = i_conv_result > i_compare_value;
        end else begin
            cmp_true = i_conv_result <= i_compare_value;
        end
    end
    assign running = (state_reg == ST_RUN);
    assign abort_running = abort_req & running;
    // An abort in the same cycle swallows the conversion
    assign conv_taken = running & i_conv_done & ~abort_req;
    // Compare value must already sit in the result register; nothing here checks it
    assign store_now = conv_taken & ~cmp_on;
    assign cmp_hit_now = conv_taken & cmp_on & cmp_true;

    // Sequence state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (seq_start && !abort_req) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (abort_req) begin
                    state_next = ST_IDLE;
                end else if (seq_end && !i_scan_mode && !i_start_write) begin
                    // A start write in the last cycle begins the next sequence
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Flag set terms
    assign seq_done_set = seq_end;
    assign trig_ovr_set = (state_reg == ST_RUN) & i_trigger_edge & ~i_trigger_level_select;
    assign res_ovr_set = store_now & i_conversion_done_flag[conversion_counter];

    // Sequence-done flag; set wins over any clear
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sequence_done_flag <= 1'b0;
        end else if (seq_done_set) begin
            sequence_done_flag <= 1'b1;
        end else if (i_start_write || (i_fast_flag_clear && i_result_read)) begin
            sequence_done_flag <= 1'b0;
        end else if (wr_status && i_wdata[`BIT_SEQ_DONE]) begin
            sequence_done_flag <= 1'b0;
        end
    end

    // Trigger overrun flag
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            trigger_overrun_flag <= 1'b0;
        end else if (trig_ovr_set) begin
            trigger_overrun_flag <= 1'b1;
        end else if (abort_req || i_start_write) begin
            trigger_overrun_flag <= 1'b0;
        end else if (wr_status && i_wdata[`BIT_TRIG_OVR]) begin
            trigger_overrun_flag <= 1'b0;
        end
    end

    // Result overrun flag
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            result_overrun_flag <= 1'b0;
        end else if (res_ovr_set) begin
            result_overrun_flag <= 1'b1;
        end else if (abort_req || i_start_write) begin
            result_overrun_flag <= 1'b0;
        end else if (wr_status && i_wdata[`BIT_RES_OVR]) begin
            result_overrun_flag <= 1'b0;
        end
    end

    // Conversion counter; the status write never reaches it
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            conversion_counter <= `CNT_ZERO;
        end else if (abort_req || seq_start) begin
            conversion_counter <= `CNT_ZERO;
        end else if (seq_end && !i_fifo_mode) begin
            conversion_counter <= `CNT_ZERO;
        end else if ((state_reg == ST_RUN) && i_conv_done) begin
            // Natural 4-bit overflow gives the wrap in FIFO mode
            conversion_counter <= conversion_counter + `CNT_ONE;
        end
    end

    // Compare enable register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            compare_enable_reg <= `CMP_RESET;
        end else if (wr_cmp) begin
            compare_enable_reg <= i_wdata;
        end
    end

    // Result store strobe
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_result_store <= 1'b0;
        end else begin
            o_result_store <= store_now;
        end
    end

    // Result index, the counter value at the conversion
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_result_index <= `CNT_ZERO;
        end else begin
            o_result_index <= conversion_counter;
        end
    end

    // Result data; only meaningful beside the store strobe
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_result_data <= {`RESULT_W{1'b0}};
        end else begin
            o_result_data <= i_conv_result;
        end
    end

    // With compare on, the flag only marks a true comparison
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_conversion_done_set <= 1'b0;
        end else begin
            o_conversion_done_set <= store_now | cmp_hit_now;
        end
    end

    // Abort strobe only when a sequence was really running
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_abort <= 1'b0;
        end else begin
            o_abort <= abort_running;
        end
    end

    // Taken from the next state so it always matches the state register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_running <= 1'b0;
        end else begin
            o_running <= (state_next == ST_RUN);
        end
    end

    // Interrupt status and mask
    always_comb begin
        irq_set = {`IRQ_W{1'b0}};
        irq_set[`IRQ_SEQ_DONE] = seq_done_set;
        irq_set[`IRQ_TRIG_OVR] = trig_ovr_set;
        irq_set[`IRQ_RES_OVR] = res_ovr_set;
        irq_status_next = irq_status_reg;
        if (wr_irq_status) begin
            irq_status_next = irq_status_reg & ~i_wdata[`IRQ_W-1:0];
        end
        // Set after clear so a coincident event is kept
        irq_status_next = irq_status_next | irq_set;
        irq_mask_next = irq_mask_reg;
        if (wr_irq_mask) begin
            irq_mask_next = i_wdata[`IRQ_W-1:0];
        end
    end

    // Event bits; a set in the clearing cycle wins
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_status_reg <= `IRQ_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Mask, plain read-write
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_mask_reg <= `IRQ_RESET;
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    // Registered from next values so the line tracks status without lag
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status_next & irq_mask_next);
        end
    end

    // Status byte; the counter bits ignore writes
    always_comb begin
        status_word = `RDATA_ZERO;
        status_word[`BIT_SEQ_DONE] = sequence_done_flag;
        status_word[`BIT_TRIG_OVR] = trigger_overrun_flag;
        status_word[`BIT_RES_OVR] = result_overrun_flag;
        status_word[`CNT_MSB:`CNT_LSB] = conversion_counter;
    end

    // Read mux; unmapped addresses and idle cycles read zero
    always_comb begin
        rdata_next = `RDATA_ZERO;
        if (!i_rd) begin
            rdata_next = `RDATA_ZERO;
        end else if (hit(i_addr, `OFS_STATUS)) begin
            rdata_next = status_word;
        end else if (hit(i_addr, `OFS_CMP_ENABLE)) begin
            rdata_next = compare_enable_reg;
        end else if (hit(i_addr, `OFS_IRQ_STATUS)) begin
            rdata_next = {{(`DATA_W-`IRQ_W){1'b0}}, irq_status_reg};
        end else if (hit(i_addr, `OFS_IRQ_MASK)) begin
            rdata_next = {{(`DATA_W-`IRQ_W){1'b0}}, irq_mask_reg};
        end else if (hit(i_addr, `OFS_ENGINE)) begin
            rdata_next = {{(`DATA_W-1){1'b0}}, running};
        end
    end

    // Read data, one cycle after the strobe and only then
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= `RDATA_ZERO;
        end else begin
            o_rdata <= rdata_next;
        end
    end

endmodule

// File: tb_top.sv
`timescale 1ns/1ns
`include "adc_seq_params.svh"
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    import adc_seq_pkg::*;
    logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, o_result_store, o_conversion_done_set, o_abort, o_running;
    logic i_fifo_mode = 0, i_scan_mode = 0, i_trigger_level_select = 0, i_fast_flag_clear = 0, o_irq;
    logic i_trigger_edge = 0, i_conv_done = 0, i_conv_last = 0;
    // Strobes: control, start, operator, result read
    logic [3:0] strb = '0;
    logic [`ADDR_W-1:0] i_addr = '0;
    logic [`DATA_W-1:0] i_wdata = '0, o_rdata, d;
    logic [`RESULT_W-1:0] i_conv_result = '0, i_compare_value = '0, o_result_data;
    logic [`POS_N-1:0] i_compare_higher_select = '0, i_conversion_done_flag = '0;
    conv_index_t o_result_index;
    int failures = 0, checked = 0, sdone, tovr, rovr, cnt, run, compare_enable_bits, irqs, mask, ab;
    logic [15:0] wv[3] = '{16'h000f, 16'h0080, 16'h0020};
    always #20 i_clk = ~i_clk;
    adc_sequence_status_compare u_adc_sequence_status_compare (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_ctl_write(strb[0]), .i_start_write(strb[1]), .i_operator_write(strb[2]),
        .i_result_read(strb[3]), .i_fifo_mode, .i_scan_mode, .i_trigger_level_select, .i_fast_flag_clear,
        .i_trigger_edge, .i_conv_done, .i_conv_last, .i_conv_result, .i_compare_value,
        .i_compare_higher_select, .i_conversion_done_flag, .o_result_store, .o_result_index,
        .o_result_data, .o_conversion_done_set, .o_abort, .o_running, .o_irq);
    function automatic void halt();
        if (run) cnt = 0;
        {run, tovr, rovr} = '0;
    endfunction
    task automatic bus(input bit w, input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] v);
        @(posedge i_clk);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 0;
        i_rd <= 0;
        @(negedge i_clk);
        d = o_rdata;
    endtask
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] v);
        ab = run && a == `OFS_CMP_ENABLE;
        bus(1, a, v);
        `CHK("abort", ab, o_abort)
        if (a == `OFS_STATUS) begin
            sdone &= !v[7];
            tovr &= !v[5];
            rovr &= !v[4];
        end
        if (a == `OFS_CMP_ENABLE) compare_enable_bits = v;
        if (a == `OFS_CMP_ENABLE) halt();
        if (a == `OFS_IRQ_STATUS) irqs &= ~v;
        if (a == `OFS_IRQ_MASK) mask = v;
    endtask
    task automatic pulse(input int k);
        ab = run && (k == 0 || k == 2);
        @(posedge i_clk);
        strb[k] <= 1;
        @(posedge i_clk);
        strb <= '0;
        @(negedge i_clk);
        `CHK("abort", ab, o_abort)
        if (k == 0 || k == 2) halt();
        if (k == 1) {sdone, tovr, rovr, cnt, run} = 1;
        if (k == 3 && i_fast_flag_clear) sdone = 0;
    endtask
    task automatic trig(input bit lvl);
        @(posedge i_clk);
        i_trigger_edge <= 1;
        i_trigger_level_select <= lvl;
        @(posedge i_clk);
        i_trigger_edge <= 0;
        if (run && !lvl) {tovr, irqs} = {32'd1, irqs | 2};
    endtask
    task automatic conv(input bit last, input logic [`POS_N-1:0] f);
        logic [`RESULT_W-1:0] r, c;
        bit hit;
        r = `RESULT_W'($urandom);
        c = `RESULT_W'($urandom);
        @(posedge i_clk);
        i_conv_done <= 1;
        i_conv_last <= last;
        i_conv_result <= r;
        i_compare_value <= c;
        i_conversion_done_flag <= f;
        @(posedge i_clk);
        i_conv_done <= 0;
        @(negedge i_clk);
        hit = i_compare_higher_select[cnt] ? r > c : r <= c;
        `CHK("store", !compare_enable_bits[cnt], o_result_store)
        `CHK("done set", compare_enable_bits[cnt] ? hit : 1, o_conversion_done_set)
        `CHK("index", cnt, o_result_index)
        if (!compare_enable_bits[cnt]) `CHK("data", r, o_result_data)
        if (!compare_enable_bits[cnt] && f[cnt]) {rovr, irqs} = {32'd1, irqs | 4};
        cnt = (cnt + 1) % 16;
        if (last) begin
            {sdone, irqs} = {32'd1, irqs | 1};
            if (!i_fifo_mode) cnt = 0;
            run = i_scan_mode;
        end
    endtask
    task automatic chk();
        bus(0, `OFS_STATUS, '0);
        `CHK("status", {sdone[0], 1'b0, tovr[0], rovr[0], cnt[3:0]}, d)
        `CHK("running", run, o_running)
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #(40 * 2000);
        failures++;
        end_of_test();
    end
    initial begin
        void'($urandom(55));
        repeat (2) @(posedge i_clk);
        i_reset <= 0;
        chk();
        bus(0, `OFS_CMP_ENABLE, '0);
        `CHK("compare reset", 0, d)
        bus(0, 5'h1e, '0);
        `CHK("unmapped", 0, d)
        $display("reset test done");
        pulse(1);
        for (int i = 0; i < 6; i++) begin
            conv(i == 5, 16'h0004);
            if (i < 2) trig(!i[0]);
            chk();
        end
        foreach (wv[i]) begin
            wr(`OFS_STATUS, wv[i]);
            chk();
        end
        pulse(0);
        chk();
        $display("single sequence test done");
        @(posedge i_clk);
        i_fifo_mode <= 1;
        i_scan_mode <= 1;
        pulse(1);
        // Runs past index 15 to cover the wrap
        for (int i = 0; i < 19; i++) conv(i % 4 == 3, '0);
        chk();
        wr(`OFS_STATUS, 16'h000c);
        chk();
        pulse(1);
        chk();
        wr(`OFS_CMP_ENABLE, 16'h000a);
        chk();
        $display("fifo test done");
        @(posedge i_clk);
        i_fifo_mode <= 0;
        i_scan_mode <= 0;
        i_compare_higher_select <= 16'($urandom);
        pulse(1);
        chk();
        for (int i = 0; i < 4; i++) conv(i == 3, 16'hffff);
        chk();
        bus(0, `OFS_CMP_ENABLE, '0);
        `CHK("compare enable", 16'h000a, d)
        pulse(2);
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk);
            i_fast_flag_clear <= i[0];
            pulse(3);
            chk();
        end
        $display("compare test done");
        for (int i = 0; i < 3; i++) begin
            wr(i < 2 ? `OFS_IRQ_MASK : `OFS_IRQ_STATUS, i == 0 ? 16'h0000 : 16'h0007);
            repeat (2) @(negedge i_clk);
            `CHK("irq", (irqs & mask) != 0, o_irq)
        end
        $display("interrupt test done");
        end_of_test();
    end
endmodule
